// >>> hw/tps_sequencer.sv
// Operation
// - start pin rising edge begins conversion and puts input stage in hold.
// - input hold follows edge by about 50 ns; busy drops at start.
// - first pass lasts 3.35 us from start before second pass.
// - first pass yields 9 top bits, kept for correction.
// - feedback dac gets first bits on top, low 7 bits always zero.
// - second pass waits until dac and residue amplifier settle.
// - residue input opens, feedback closes, then residue stage holds.
// - input stage returns to track once residue stage holds.
// - second 9-bit code is latched, then merged with correction.
// - final result is twos complement for both ranges.
// - starts are accepted no faster than 166 kSPS.
// - busy stays low the whole conversion, rises at completion.
// - start pin is asynchronous and synchronised inside.
`timescale 1ns/1ps
module tps_sequencer
  import tps_pkg::*;
(
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // host side
  input  wire logic                       conversion_start_n,
  output logic                            busy_n,
  output logic      [tps_pkg::RES_W-1:0]  result,
  output logic                            result_ready,
  // flash converter
  input  wire logic [tps_pkg::PASS_W-1:0] flash_code,
  // analog switch and dac controls, high means closed or hold
  output logic                            input_track_switch,
  output logic                            residue_input_switch,
  output logic                            residue_feedback_switch,
  output logic                            residue_hold,
  output logic      [tps_pkg::RES_W-1:0]  dac_word
);

  tps_state_t             state;
  tps_state_t             next_state;
  logic [CNT_W-1:0]       cnt;
  logic [CNT_W-1:0]       next_cnt;
  logic [CNT_W-1:0]       gap;
  logic [CNT_W-1:0]       next_gap;
  logic                   next_busy_n;
  logic                   next_input_track_switch;
  logic                   next_residue_input_switch;
  logic                   next_residue_feedback_switch;
  logic                   next_residue_hold;
  logic [RES_W-1:0]       next_dac_word;
  logic [PASS_W-1:0]      first_code;
  logic [PASS_W-1:0]      next_first_code;
  logic [PASS_W-1:0]      second_code;
  logic [PASS_W-1:0]      next_second_code;
  logic [RES_W-1:0]       next_result;
  logic                   next_result_ready;
  logic [RES_W-1:0]       corrected;
  logic                   start_pulse;
  logic                   accept;
  logic                   cnt_done;

  // ------------------------------------------------------------------
  // start input
  // ------------------------------------------------------------------
  tps_start_sync u_start_sync (
    .clk                (clk),
    .rst                (rst),
    .conversion_start_n (conversion_start_n),
    .start_pulse        (start_pulse)
  );

  // ------------------------------------------------------------------
  // result arithmetic
  // ------------------------------------------------------------------
  tps_correct u_correct (
    .first_code  (first_code),
    .second_code (second_code),
    .corrected   (corrected)
  );

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  assign cnt_done = (cnt == '0);
  // a start while busy or too soon after the last one is dropped
  assign accept = (state == TPS_IDLE) && start_pulse && (gap == '0);

  always_comb begin
    next_state                   = state;
    next_cnt                     = cnt;
    next_gap                     = (gap == '0) ? gap : gap - ONE_CYC;
    next_busy_n                  = busy_n;
    next_input_track_switch      = input_track_switch;
    next_residue_input_switch    = residue_input_switch;
    next_residue_feedback_switch = residue_feedback_switch;
    next_residue_hold            = residue_hold;
    next_dac_word                = dac_word;
    next_first_code              = first_code;
    next_second_code             = second_code;
    next_result                  = result;
    next_result_ready            = 1'h0;
    if (!cnt_done) begin
      next_cnt = cnt - ONE_CYC;
    end
    case (state)
      TPS_IDLE: begin
        if (accept) begin
          next_busy_n = 1'h0;
          next_gap    = MIN_PERIOD_CYC - ONE_CYC;
          next_cnt    = HOLD_CYC - ONE_CYC;
          next_state  = TPS_APERTURE;
        end
      end
      TPS_APERTURE: begin
        if (cnt_done) begin
          // aperture delay rounded up to whole cycles
          next_input_track_switch = 1'h0;
          next_cnt   = PHASE1_CYC - HOLD_CYC - ONE_CYC;
          next_state = TPS_PHASE1;
        end
      end
      TPS_PHASE1: begin
        if (cnt_done) begin
          next_first_code = flash_code;
          next_dac_word   = {flash_code, DAC_LSB_ZERO};
          next_cnt        = SETTLE_CYC - ONE_CYC;
          next_state      = TPS_SETTLE;
        end
      end
      TPS_SETTLE: begin
        if (cnt_done) begin
          next_residue_input_switch    = 1'h0;
          next_residue_feedback_switch = 1'h1;
          next_cnt   = SWITCH_CYC - ONE_CYC;
          next_state = TPS_SW_STEP;
        end
      end
      TPS_SW_STEP: begin
        if (cnt_done) begin
          next_residue_hold = 1'h1;
          next_cnt   = SWITCH_CYC - ONE_CYC;
          next_state = TPS_RES_HOLD;
        end
      end
      TPS_RES_HOLD: begin
        if (cnt_done) begin
          // reacquisition overlaps the second pass
          next_input_track_switch = 1'h1;
          next_cnt   = PHASE2_CYC - ONE_CYC;
          next_state = TPS_PHASE2;
        end
      end
      TPS_PHASE2: begin
        if (cnt_done) begin
          next_second_code = flash_code;
          next_state       = TPS_CORRECT;
        end
      end
      TPS_CORRECT: begin
        next_result                  = corrected;
        next_result_ready            = 1'h1;
        next_busy_n                  = 1'h1;
        next_residue_hold            = 1'h0;
        next_residue_input_switch    = 1'h1;
        next_residue_feedback_switch = 1'h0;
        next_state                   = TPS_IDLE;
      end
      default: begin
        next_state = TPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state                   <= TPS_IDLE;
      cnt                     <= '0;
      gap                     <= '0;
      busy_n                  <= 1'h1;
      input_track_switch      <= 1'h1;
      residue_input_switch    <= 1'h1;
      residue_feedback_switch <= 1'h0;
      residue_hold            <= 1'h0;
      dac_word                <= RESULT_RESET;
      first_code              <= PASS_RESET;
      second_code             <= PASS_RESET;
      result                  <= RESULT_RESET;
      result_ready            <= 1'h0;
    end else begin
      state                   <= next_state;
      cnt                     <= next_cnt;
      gap                     <= next_gap;
      busy_n                  <= next_busy_n;
      input_track_switch      <= next_input_track_switch;
      residue_input_switch    <= next_residue_input_switch;
      residue_feedback_switch <= next_residue_feedback_switch;
      residue_hold            <= next_residue_hold;
      dac_word                <= next_dac_word;
      first_code              <= next_first_code;
      second_code             <= next_second_code;
      result                  <= next_result;
      result_ready            <= next_result_ready;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  localparam int P1_DLY     = int'(PHASE1_CYC);
  localparam int SETTLE_AGE = int'(SETTLE_CYC);

  // cycles since the dac was last loaded, saturating
  logic [CNT_W-1:0] dac_age;
  always_ff @(posedge clk) begin
    if (rst) begin
      dac_age <= '0;
    end else if (state == TPS_PHASE1 && cnt_done) begin
      dac_age <= '0;
    end else if (dac_age != '1) begin
      dac_age <= dac_age + ONE_CYC;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence aperture_s;
    input_track_switch [*3] ##1 !input_track_switch;
  endsequence

  sequence residue_steps_s;
    residue_feedback_switch && !residue_hold ##1 residue_hold
      ##1 input_track_switch;
  endsequence

  start_hold_a: assert property (accept |=> aperture_s)
    else $error("input stage did not hold three cycles after start");

  busy_fall_a: assert property (accept |=> !busy_n)
    else $error("busy did not drop at conversion start");

  // dac and first code are loaded at the edge after the count ends
  phase1_len_a: assert property (
    accept |=> ##P1_DLY (dac_word[RES_W-1:DAC_LSB_W] == $past(flash_code)
      && first_code == $past(flash_code)))
    else $error("first pass code not taken at end of first phase");

  dac_low_zero_a: assert property (
    dac_word[DAC_LSB_W-1:0] == DAC_LSB_ZERO)
    else $error("dac low bits not zero");

  settle_wait_a: assert property (
    $rose(residue_feedback_switch) |-> dac_age == CNT_W'(SETTLE_AGE))
    else $error("residue switches moved before settling time");

  residue_order_a: assert property (
    $fell(residue_input_switch) |-> residue_steps_s)
    else $error("residue switch and hold order wrong");

  busy_rise_a: assert property (
    $rose(busy_n) |-> result_ready && $past(state) == TPS_CORRECT)
    else $error("busy rose without a completed result");

  busy_span_a: assert property (
    accept |=> !busy_n until result_ready)
    else $error("busy rose before the result");

  conv_bound_a: assert property (accept |-> ##[1:300] result_ready)
    else $error("conversion did not finish in time");

  rate_guard_a: assert property (
    (state == TPS_IDLE && gap != '0) |=> state == TPS_IDLE)
    else $error("start accepted faster than the highest rate");

  first_code_a: assert property (
    $changed(first_code) |-> $past(state) == TPS_PHASE1)
    else $error("first pass code changed outside the first phase");

  settle_still_a: assert property (
    state == TPS_SETTLE |-> residue_input_switch
      && !residue_feedback_switch && !residue_hold)
    else $error("residue stage moved while settling");

  track_resume_a: assert property (
    $rose(input_track_switch) |-> residue_hold && $past(residue_hold))
    else $error("input stage tracked before residue stage held");

  second_take_a: assert property (
    (state == TPS_PHASE2 && cnt_done)
      |=> second_code == $past(flash_code))
    else $error("second pass code not taken at end of second phase");

  result_change_a: assert property (
    $changed(result) |-> result_ready)
    else $error("result changed without ready");

  hold_busy_a: assert property (
    !input_track_switch |-> !busy_n)
    else $error("input stage held outside a conversion");

  busy_state_a: assert property (
    !busy_n == (state != TPS_IDLE))
    else $error("busy does not match the conversion state");

  idle_rest_a: assert property (
    state == TPS_IDLE |-> input_track_switch && residue_input_switch
      && !residue_feedback_switch && !residue_hold)
    else $error("switches not at rest while idle");

endmodule // tps_sequencer

// >>> hw/tps_pkg.sv
package tps_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int CNT_W           = 9;

  // aperture from start edge to input hold, least time
  localparam int HOLD_DELAY_NS   = 50;
  // first pass, measured from the start of conversion
  localparam int PHASE1_NS       = 3350;
  // dac and residue amplifier settling, plain default
  localparam int SETTLE_NS       = 500;
  // spacing between residue switch steps, plain default
  localparam int SWITCH_NS       = 20;
  // second pass flash conversion, plain default
  localparam int PHASE2_NS       = 1500;
  // highest start rate, samples per second
  localparam int MAX_RATE_SPS    = 166000;
  localparam int MIN_PERIOD_NS   =
    (1000000000 + MAX_RATE_SPS - 1) / MAX_RATE_SPS;

  localparam logic [CNT_W-1:0] HOLD_CYC   =
    CNT_W'((HOLD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PHASE1_CYC =
    CNT_W'((PHASE1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SETTLE_CYC =
    CNT_W'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SWITCH_CYC =
    CNT_W'((SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PHASE2_CYC =
    CNT_W'((PHASE2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MIN_PERIOD_CYC =
    CNT_W'((MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ONE_CYC    = 9'h001;

  // ------------------------------------------------------------------
  // data layout
  // ------------------------------------------------------------------
  localparam int PASS_W          = 9;
  localparam int RES_W           = 16;
  localparam int DAC_LSB_W       = 7;
  localparam logic [DAC_LSB_W-1:0] DAC_LSB_ZERO = 7'h00;
  // offset the residue amplifier adds, plain default
  localparam logic [RES_W-1:0] RESIDUE_OFFSET = 16'h0040;
  localparam logic [RES_W-1:0] SIGN_FLIP      = 16'h8000;
  localparam logic [RES_W-1:0] RESULT_RESET   = 16'h0000;
  localparam logic [PASS_W-1:0] PASS_RESET    = 9'h000;

  // ------------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    TPS_IDLE,
    TPS_APERTURE,
    TPS_PHASE1,
    TPS_SETTLE,
    TPS_SW_STEP,
    TPS_RES_HOLD,
    TPS_PHASE2,
    TPS_CORRECT
  } tps_state_t;

endpackage

// >>> hw/tps_start_sync.sv
`timescale 1ns/1ps
module tps_start_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // asynchronous start pin
  input  wire logic conversion_start_n,
  // one-cycle pulse on its low-to-high edge
  output logic      start_pulse
);

  logic meta;
  logic stable;
  logic delayed;
  logic next_meta;
  logic next_stable;
  logic next_delayed;

  // ------------------------------------------------------------------
  // two-stage synchroniser and edge detect
  // ------------------------------------------------------------------
  // the pin idles high, so reset holds the stages high to avoid a
  // false edge after release
  always_comb begin
    next_meta    = conversion_start_n;
    next_stable  = meta;
    next_delayed = stable;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta    <= 1'h1;
      stable  <= 1'h1;
      delayed <= 1'h1;
    end else begin
      meta    <= next_meta;
      stable  <= next_stable;
      delayed <= next_delayed;
    end
  end

  // only the second stage and its delayed copy feed the detector
  assign start_pulse = stable & ~delayed;

endmodule // tps_start_sync

// >>> hw/tps_correct.sv
`timescale 1ns/1ps
module tps_correct
  import tps_pkg::*;
(
  // both pass codes
  input  wire logic [tps_pkg::PASS_W-1:0] first_code,
  input  wire logic [tps_pkg::PASS_W-1:0] second_code,
  // merged result, twos complement
  output logic      [tps_pkg::RES_W-1:0]  corrected
);

  logic signed [RES_W+1:0] sum;
  logic        [RES_W-1:0] clipped;

  // ------------------------------------------------------------------
  // error correction
  // ------------------------------------------------------------------
  // the residue pass overlaps the first by its offset, so coarse
  // errors of the first pass are absorbed by the sum; extremes clip
  always_comb begin
    sum = $signed({2'h0, first_code, DAC_LSB_ZERO})
        + $signed({{(RES_W+2-PASS_W){1'h0}}, second_code})
        - $signed({2'h0, RESIDUE_OFFSET});
    if (sum < 0) begin
      clipped = RESULT_RESET;
    end else if (sum[RES_W+1:RES_W] != 2'h0) begin
      clipped = ~RESULT_RESET;
    end else begin
      clipped = sum[RES_W-1:0];
    end
    // offset binary to twos complement, same for both ranges
    corrected = clipped ^ SIGN_FLIP;
  end

endmodule // tps_correct

// >>> tb/tps_host_model.sv
`timescale 1ns/1ps
module tps_host_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // bench requests
  input  wire logic go,
  input  wire logic force_go,
  // device side
  input  wire logic busy_n,
  output logic      conversion_start_n
);
  logic [2:0] cnt;

  // ----------------------------------------------------------------
  // start pulse: low for three cycles, then the rising edge
  // ----------------------------------------------------------------
  // a plain host holds off while busy; force_go breaks that on purpose
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt                <= 3'h0;
      conversion_start_n <= 1'b1;
    end else if (cnt != 3'h0) begin
      cnt                <= cnt - 3'h1;
      conversion_start_n <= (cnt == 3'h1);
    end else if ((go && busy_n) || force_go) begin
      cnt                <= 3'h3;
      conversion_start_n <= 1'b0;
    end
  end
endmodule // tps_host_model

// >>> tb/tb_tps_sequencer.sv
`timescale 1ns/1ps
module tb_tps_sequencer;
  import tps_pkg::*;
  logic                clk;
  logic                rst;
  logic                go;
  logic                force_go;
  logic                conversion_start_n;
  logic                busy_n;
  logic                result_ready;
  logic [RES_W-1:0]    result;
  logic [RES_W-1:0]    dac_word;
  logic [PASS_W-1:0]   flash_code;
  logic                input_track_switch;
  logic                residue_input_switch;
  logic                residue_feedback_switch;
  logic                residue_hold;
  logic [31:0]         seed;
  int                  n_errors;
  int                  num_checks;
  int                  i;

  tps_sequencer i_tps_sequencer (
    .clk                     (clk),
    .rst                     (rst),
    .conversion_start_n      (conversion_start_n),
    .busy_n                  (busy_n),
    .result                  (result),
    .result_ready            (result_ready),
    .flash_code              (flash_code),
    .input_track_switch      (input_track_switch),
    .residue_input_switch    (residue_input_switch),
    .residue_feedback_switch (residue_feedback_switch),
    .residue_hold            (residue_hold),
    .dac_word                (dac_word)
  );

  tps_host_model i_tps_host_model (
    .clk                (clk),
    .rst                (rst),
    .go                 (go),
    .force_go           (force_go),
    .busy_n             (busy_n),
    .conversion_start_n (conversion_start_n)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // offset-binary sum clipped to full scale, then sign bit flipped
  function automatic logic [RES_W-1:0] expect_res(
    input logic [PASS_W-1:0] a, input logic [PASS_W-1:0] b);
    int s;
    s = int'(a) * 128 + int'(b) - int'(RESIDUE_OFFSET);
    if (s < 0) s = 0;
    if (s > 65535) s = 65535;
    return RES_W'(s) ^ SIGN_FLIP;
  endfunction

  task automatic chk_bit(input logic got, input logic exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic chk_word(input logic [RES_W-1:0] got,
                          input logic [RES_W-1:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s %h vs %h", $time, m, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // one conversion, switch, busy and ready ports checked on every cycle
  // ----------------------------------------------------------------
  // d counts cycles from the one where busy_n is first seen low
  task automatic conv(input logic [PASS_W-1:0] c1,
                      input logic [PASS_W-1:0] c2, input bit intrude);
    logic [RES_W-1:0] e;
    int               d;
    int               w;
    e = expect_res(c1, c2);
    @(posedge clk);
    flash_code <= c1;
    go         <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    w = 0;
    while (busy_n !== 1'b0 && w < 20) begin
      @(posedge clk);
      #1;
      w++;
    end
    chk_bit(busy_n, 1'b0, "no start");
    for (d = 0; d <= 271; d++) begin
      chk_bit(busy_n, d >= 271, "busy");
      chk_bit(input_track_switch, d < 3 || d >= 195, "track");
      chk_bit(residue_input_switch, d < 193 || d >= 271, "res in");
      chk_bit(residue_feedback_switch, d >= 193 && d < 271, "fb");
      chk_bit(residue_hold, d >= 194 && d < 271, "res hold");
      chk_bit(result_ready, d == 271, "ready");
      if (d >= 168) chk_word(dac_word, {c1, DAC_LSB_ZERO}, "dac");
      if (d == 271) chk_word(result, e, "result");
      @(posedge clk);
      if (d == 167) flash_code <= c2;
      if (intrude) force_go <= (d == 50);
      #1;
    end
  endtask

  // a start too soon after the last accept must leave busy_n high
  task automatic quiet(input int n);
    int k;
    for (k = 0; k < n; k++) begin
      @(posedge clk);
      #1;
      chk_bit(busy_n, 1'b1, "refused start");
      chk_bit(result_ready, 1'b0, "ready idle");
    end
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  // eight conversions of some 320 cycles each, with margin
  initial begin
    #(CLK_PERIOD_NS * 20000);
    n_errors++;
    wrap_up();
  end

  initial begin
    rst        = 1'b1;
    go         = 1'b0;
    force_go   = 1'b0;
    flash_code = PASS_RESET;
    seed       = 32'hbf28_82d1;
    n_errors   = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_bit(busy_n, 1'b1, "reset busy");
    chk_bit(input_track_switch, 1'b1, "reset track");
    chk_word(result, RESULT_RESET, "reset result");
    conv(9'h000, 9'h000, 1'b0);
    quiet(40);
    conv(9'h1ff, 9'h1ff, 1'b1);
    @(posedge clk);
    force_go <= 1'b1;
    @(posedge clk);
    force_go <= 1'b0;
    quiet(40);
    for (i = 0; i < 6; i++) begin
      seed = lfsr_next(seed);
      conv(seed[8:0], seed[24:16], i[0]);
      quiet(40);
    end
    wrap_up();
  end
endmodule // tb_tps_sequencer
